// ### hw/pdoe_defines.svh
// register offsets, reset values and field layout for the port d/e/f drive-enable bank
`ifndef PDOE_DEFINES_SVH
`define PDOE_DEFINES_SVH
// =====================================================
// register indices and byte addresses
`define PDOE_D_INDEX    16'h30B3
`define PDOE_E_INDEX    16'h30B4
`define PDOE_F_INDEX    16'h30B5
`define PDOE_D_ADDR     (`PDOE_D_INDEX * 4)
`define PDOE_E_ADDR     (`PDOE_E_INDEX * 4)
`define PDOE_F_ADDR     (`PDOE_F_INDEX * 4)
// =====================================================
// widths and reset values
`define PDOE_PINS       8
`define PDOE_RESET      8'h00
`endif

// ### hw/pdoe_pkg.sv
// types shared by the port d/e/f drive-enable bank
package pdoe_pkg;
	// =====================================================
	// register selector
	typedef enum logic [1:0] {
		PDOE_SEL_NONE,
		PDOE_SEL_D,
		PDOE_SEL_E,
		PDOE_SEL_F
	} pdoe_sel_e;

	// one output-enable byte per port
	typedef struct packed {
		logic [7:0] d;                        // port d pin drivers
		logic [7:0] e;                        // port e pin drivers
		logic [7:0] f;                        // port f pin drivers
	} pdoe_oe_s;
endpackage : pdoe_pkg

// ### hw/pdoe_bank.sv
// apb slave holding the port d, e and f output-drive enable registers
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "pdoe_defines.svh"

module pdoe_bank #(
	parameter int ADDR_W = 18                 // byte address width
) (
	input  wire logic              pclk,      // bus clock
	input  wire logic              presetn,   // async reset, low
	input  wire logic              psel,      // slave select
	input  wire logic              penable,   // access phase
	input  wire logic              pwrite,    // write direction
	input  wire logic [ADDR_W-1:0] paddr,     // byte address
	input  wire logic [31:0]       pwdata,    // write data
	input  wire logic [3:0]        pstrb,     // byte strobes
	output logic                   pready,    // always ready
	output logic [31:0]            prdata,    // read data
	output logic                   pslverr,   // unmapped access
	output pdoe_pkg::pdoe_oe_s     pin_oe     // per-pin driver enables
);
	import pdoe_pkg::*;

	// =====================================================
	// address decode
	// used by both the write path and the read path
	function automatic pdoe_sel_e pdoe_decode(input logic [ADDR_W-1:0] a);
		if (a == ADDR_W'(`PDOE_D_ADDR)) begin
			return PDOE_SEL_D;
		end else if (a == ADDR_W'(`PDOE_E_ADDR)) begin
			return PDOE_SEL_E;
		end else if (a == ADDR_W'(`PDOE_F_ADDR)) begin
			return PDOE_SEL_F;
		end else begin
			return PDOE_SEL_NONE;
		end
	endfunction : pdoe_decode

	// =====================================================
	// state
	pdoe_oe_s    oe_q, oe_d;                  // drive enable registers
	logic [31:0] rdata_q, rdata_d;            // read data captured in setup
	logic        err_q, err_d;                // unmapped flag captured in setup
	pdoe_sel_e   sel;                         // decoded current address
	logic        setup;                       // setup cycle of a transfer
	logic        wr_acc;                      // write access phase

	assign sel    = pdoe_decode(paddr);
	assign setup  = psel & ~penable;
	assign wr_acc = psel & penable & pwrite & pready;

	// =====================================================
	// next-state logic
	// read data is latched at the setup edge so prdata comes from a flop
	// and still answers with zero wait states
	always_comb begin
		oe_d    = oe_q;
		rdata_d = rdata_q;
		err_d   = err_q;
		if (wr_acc && pstrb[0]) begin       // writes land only at access edge
			case (sel)
				PDOE_SEL_D: oe_d.d = pwdata[7:0];
				PDOE_SEL_E: oe_d.e = pwdata[7:0];
				PDOE_SEL_F: oe_d.f = pwdata[7:0];
				default:    oe_d   = oe_q;         // unmapped, nothing stored
			endcase
		end
		if (setup) begin                      // capture answer for access phase
			err_d = (sel == PDOE_SEL_NONE);
			case (sel)
				PDOE_SEL_D: rdata_d = {24'h00_0000, oe_q.d};
				PDOE_SEL_E: rdata_d = {24'h00_0000, oe_q.e};
				PDOE_SEL_F: rdata_d = {24'h00_0000, oe_q.f};
				default:    rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// registers only; all clear so every driver starts off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oe_q.d  <= `PDOE_RESET;
			oe_q.e  <= `PDOE_RESET;
			oe_q.f  <= `PDOE_RESET;
			rdata_q <= 32'h0000_0000;
			err_q   <= 1'b0;
		end else begin
			oe_q    <= oe_d;
			rdata_q <= rdata_d;
			err_q   <= err_d;
		end
	end

	// =====================================================
	// outputs
	assign pready  = 1'b1;                    // no wait states needed
	assign prdata  = rdata_q;
	assign pslverr = psel & penable & err_q;
	assign pin_oe  = oe_q;                    // a one bit turns the driver on

	// =====================================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence wr_to(logic [ADDR_W-1:0] a);
		psel && penable && pwrite && pstrb[0] && paddr == a;
	endsequence

	d_write_a: assert property (wr_to(ADDR_W'(`PDOE_D_ADDR)) |=> pin_oe.d == $past(pwdata[7:0]))
		else $error("port d write not applied");
	e_write_a: assert property (wr_to(ADDR_W'(`PDOE_E_ADDR)) |=> pin_oe.e == $past(pwdata[7:0]))
		else $error("port e write not applied");
	f_write_a: assert property (wr_to(ADDR_W'(`PDOE_F_ADDR)) |=> pin_oe.f == $past(pwdata[7:0]))
		else $error("port f write not applied");
	drive_hold_a: assert property (!(psel && penable && pwrite) |=> $stable(pin_oe))
		else $error("drive enables changed without a write");
	read_back_a: assert property (psel && !penable && !pwrite && paddr == ADDR_W'(`PDOE_E_ADDR) ##1
		psel && penable |-> prdata == {24'h00_0000, pin_oe.e})
		else $error("port e read back mismatch");
	unmapped_err_a: assert property (setup && sel == PDOE_SEL_NONE ##1 psel && penable |-> pslverr)
		else $error("unmapped access without error");
	e_reset_a: assert property (disable iff (1'b0) $rose(presetn) |-> pin_oe.e == 8'h00)
		else $error("port e not cleared by reset");
	df_reset_a: assert property (disable iff (1'b0) $rose(presetn) |-> pin_oe.d == 8'h00 && pin_oe.f == 8'h00)
		else $error("port d or f not cleared by reset");

	// =====================================================
	// read path checks
	// a read is a setup cycle on one address followed by its access phase
	sequence rd_setup(logic [ADDR_W-1:0] a);
		psel && !penable && !pwrite && paddr == a;
	endsequence

	// the access phase that completes a transfer
	sequence access_phase;
		psel && penable;
	endsequence

	// any write access phase, whatever its address or strobes
	sequence wr_access;
		psel && penable && pwrite;
	endsequence

	// port d byte comes back in the low lane
	d_read_back_a: assert property (rd_setup(ADDR_W'(`PDOE_D_ADDR)) ##1 access_phase
		|-> prdata == {24'h00_0000, pin_oe.d})
		else $error("port d read back mismatch");

	// port f byte comes back in the low lane
	f_read_back_a: assert property (rd_setup(ADDR_W'(`PDOE_F_ADDR)) ##1 access_phase
		|-> prdata == {24'h00_0000, pin_oe.f})
		else $error("port f read back mismatch");

	// upper lanes never carry anything; the registers are one byte wide
	upper_zero_a: assert property (access_phase |-> prdata[31:8] == 24'h00_0000)
		else $error("read data upper bytes not zero");

	// an unmapped read returns zero rather than a stale byte
	unmapped_zero_a: assert property (setup && sel == PDOE_SEL_NONE ##1 access_phase
		|-> prdata == 32'h0000_0000)
		else $error("unmapped read data not zero");

	// mapped registers never raise an error
	mapped_ok_a: assert property (setup && sel != PDOE_SEL_NONE ##1 access_phase |-> !pslverr)
		else $error("error raised on a mapped register");

	// the slave never stretches a transfer
	ready_tie_a: assert property (access_phase |-> pready)
		else $error("slave not ready in access phase");

	// =====================================================
	// write path checks
	// a write without the low byte strobe must leave every driver alone
	no_strobe_a: assert property (wr_access and !pstrb[0] |=> $stable(pin_oe))
		else $error("write without strobe changed drivers");

	// a write to an address outside the bank stores nothing
	unmapped_keep_a: assert property (wr_access and sel == PDOE_SEL_NONE |=> $stable(pin_oe))
		else $error("unmapped write changed drivers");

	// a write to one port leaves the other two untouched
	d_only_a: assert property (wr_to(ADDR_W'(`PDOE_D_ADDR)) |=> $stable({pin_oe.e, pin_oe.f}))
		else $error("port d write disturbed another port");
	e_only_a: assert property (wr_to(ADDR_W'(`PDOE_E_ADDR)) |=> $stable({pin_oe.d, pin_oe.f}))
		else $error("port e write disturbed another port");
	f_only_a: assert property (wr_to(ADDR_W'(`PDOE_F_ADDR)) |=> $stable({pin_oe.d, pin_oe.e}))
		else $error("port f write disturbed another port");

	// =====================================================
	// per-pin encoding checks
	// one bit per pin, so the checks repeat for every index
	// a one turns the driver on and a zero turns it off, pin by pin
	for (genvar i = 0; i < 8; i++) begin : g_pin
		// port d pin i follows its written bit
		d_bit_a: assert property (wr_to(ADDR_W'(`PDOE_D_ADDR)) |=> pin_oe.d[i] == $past(pwdata[i]))
			else $error("port d pin enable does not follow its bit");
		// port e pin i follows its written bit
		e_bit_a: assert property (wr_to(ADDR_W'(`PDOE_E_ADDR)) |=> pin_oe.e[i] == $past(pwdata[i]))
			else $error("port e pin enable does not follow its bit");
		// port f pin i follows its written bit
		f_bit_a: assert property (wr_to(ADDR_W'(`PDOE_F_ADDR)) |=> pin_oe.f[i] == $past(pwdata[i]))
			else $error("port f pin enable does not follow its bit");
	end
endmodule : pdoe_bank

// ### tb/pdoe_pins_model.sv
// model of the pins outside the bank: pins that are driven high, released pins with a pull-down
`timescale 1ns/1ps
module pdoe_pins_model (
	input  wire pdoe_pkg::pdoe_oe_s oe,  // per-pin driver enables
	output logic [23:0]             lvl  // pin levels seen outside
);
	import pdoe_pkg::*;
	// =====================================================
	// pin level
	// a released pin falls to the pull-down level, so it cannot keep showing the last driven value
	assign lvl = oe;
endmodule : pdoe_pins_model

// ### tb/test_port_def_output_enable_bank.sv
// self-checking bench for the port d/e/f drive-enable bank
`timescale 1ns/1ps
`include "pdoe_defines.svh"
module test_port_def_output_enable_bank;
	import pdoe_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
	logic [17:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	logic [3:0]  pstrb = 0;
	pdoe_oe_s    pin_oe;
	logic [23:0] lvl;
	int fails = 0, checked = 0;
	logic [17:0] adr [3] = '{18'(`PDOE_D_ADDR), 18'(`PDOE_E_ADDR), 18'(`PDOE_F_ADDR)};  // d, e, f
	logic [7:0]  val [3] = '{8'h81, 8'h5A, 8'h3C};
	always #12.5 pclk = ~pclk;
	pdoe_bank #(.ADDR_W(18)) pdoe_bank_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .pin_oe(pin_oe));
	pdoe_pins_model pdoe_pins_model_i (.oe(pin_oe), .lvl(lvl));
	// =====================================================
	// one apb transfer: setup, then access held until pready is sampled high
	task xfer(input logic w, input logic [17:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata, pstrb} <= {1'b1, 1'b0, w, a, d, s};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
	endtask : xfer
	task chk(input string n, input logic [31:0] s, input logic [31:0] x);
		checked++;
		if (s !== x) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, x, s);
		end
	endtask : chk
	task report_and_stop;
		$display("checked %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : report_and_stop
	// =====================================================
	// scenarios
	task t_reset;
		chk("pins", lvl, 0);
		chk("ready", pready, 1);
		for (int i = 0; i < 3; i++) begin
			xfer(0, adr[i], 0, 0);
			chk("reset read", r, 0);
		end
		$display("test reset done");
	endtask : t_reset
	task t_rw;
		logic [7:0] v;
		// second pass flips every bit so each bit is seen both ways
		for (int p = 0; p < 2; p++) for (int i = 0; i < 3; i++) begin
			v = p ? ~val[i] : val[i];
			xfer(1, adr[i], {24'hFFFF_FF, v}, 4'h1);
			@(negedge pclk);
			chk("pin byte", lvl[23-8*i -: 8], v);
			xfer(0, adr[i], 0, 0);
			chk("readback", r, {24'h0, v});
		end
		$display("test read write done");
	endtask : t_rw
	task t_refuse;
		xfer(1, adr[0], 0, 4'h0);
		xfer(0, adr[0], 0, 0);
		chk("no strobe", r, {24'h0, ~val[0]});
		xfer(1, adr[2] + 18'h4, 32'h0000_00FF, 4'h1);
		chk("unmapped err", e, 1);
		xfer(0, adr[2] + 18'h4, 0, 0);
		chk("unmapped read", r, 0);
		chk("pins kept", lvl, {~val[0], ~val[1], ~val[2]});
		$display("test refusal done");
	endtask : t_refuse
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_rw();
		t_refuse();
		report_and_stop();
	end
	// watchdog well past the nineteen transfers above
	initial begin
		#100000;
		fails++;
		report_and_stop();
	end
endmodule : test_port_def_output_enable_bank
